// >>> design/afb_pkg.sv
// analog function block constants, carrier types and helpers
// assumes every value with two decimals arrives scaled by 100 as a signed integer
//
// Notes on behaviour
// - scaler result is input times clamped gain plus clamped offset
// - scaler drives its scaled result on its analog output
// - scaler reset clears its result and output
// - every block copies its running value into its data word output
// - drift monitor enable rising edge latches reference and starts monitoring
// - drift output high above reference plus upper or below reference minus lower
// - drift reset clears output and stops monitoring until next enable edge
// - positive difference: trigger high while level <= value < level plus difference
// - negative difference: set above level, clear at or below level plus difference
// - trigger reset clears its state and output
// - selector output updates only on enable rising edge with selects sampled then, and clears on selector reset
// - select pair high,low 00,01,10,11 picks first to fourth preset
// - presets are clamped to -20000.00..20000.00
package afb_pkg;

  // -----------------------------------------------------------------
  // widths and scaling
  // -----------------------------------------------------------------
  localparam int AIN_W    = 32;
  localparam int PAR_W    = 16;
  localparam int VAL_W    = 48;
  localparam int NPRESET  = 4;

  localparam logic signed [VAL_W-1:0] FIX_SCALE  = 48'sd100;
  localparam logic signed [VAL_W-1:0] GAIN_MAX   = 48'sd10000;
  localparam logic signed [VAL_W-1:0] OFS_MAX    = 48'sd20000;
  localparam logic signed [VAL_W-1:0] LEVEL_MAX  = 48'sd2000000;
  localparam logic signed [VAL_W-1:0] VAL_RESET  = 48'sh0;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic signed [PAR_W-1:0] gain;
    logic signed [PAR_W-1:0] offset;
  } afb_scale_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] scaler;
    logic signed [VAL_W-1:0] drift;
    logic signed [VAL_W-1:0] window;
    logic signed [VAL_W-1:0] preset;
  } afb_dw_t;

  typedef enum logic [1:0] {
    SEL_FIRST  = 2'b00,
    SEL_SECOND = 2'b01,
    SEL_THIRD  = 2'b10,
    SEL_FOURTH = 2'b11
  } afb_sel_t;

  function automatic logic signed [VAL_W-1:0] afb_clamp(
    input logic signed [VAL_W-1:0] v,
    input logic signed [VAL_W-1:0] lo,
    input logic signed [VAL_W-1:0] hi);
    afb_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : afb_clamp

endpackage : afb_pkg

// >>> design/afb_scaler.sv
// gain and offset scaler shared by the analog blocks
// assumes input and result carry two decimals (x100), gain and offset are integers
`timescale 1ns/10ps
`default_nettype none
module afb_scaler (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            blk_rst,
  // data
  input  wire logic signed [afb_pkg::AIN_W-1:0] ain,
  input  wire afb_pkg::afb_scale_t              scale,
  output logic signed [afb_pkg::VAL_W-1:0]      aout
);
  import afb_pkg::*;

  logic signed [VAL_W-1:0] gain_c;
  logic signed [VAL_W-1:0] ofs_c;
  logic signed [VAL_W+1:0] sum;
  logic signed [VAL_W-1:0] val_d;
  logic signed [VAL_W-1:0] val_q;

  // saturation bounds of the 48-bit result, kept signed at the wider sum width
  // so that a negative sum is never compared as a huge unsigned number
  localparam logic signed [VAL_W+1:0] SUM_HI = (VAL_W+2)'(signed'({1'b0, {(VAL_W-1){1'b1}}}));
  localparam logic signed [VAL_W+1:0] SUM_LO = (VAL_W+2)'(signed'({1'b1, {(VAL_W-1){1'b0}}}));

  // -----------------------------------------------------------------
  // arithmetic
  // -----------------------------------------------------------------
  always_comb begin
    gain_c = afb_clamp(VAL_W'(scale.gain), -GAIN_MAX, GAIN_MAX);
    ofs_c  = afb_clamp(VAL_W'(scale.offset), -OFS_MAX, OFS_MAX);
    // wider sum, saturated back, so extreme inputs cannot wrap sign
    sum    = (VAL_W+2)'(VAL_W'(ain) * gain_c) + (VAL_W+2)'(ofs_c * FIX_SCALE);
    if (sum > SUM_HI) begin
      val_d = SUM_HI[VAL_W-1:0];
    end else if (sum < SUM_LO) begin
      val_d = SUM_LO[VAL_W-1:0];
    end else begin
      val_d = sum[VAL_W-1:0];
    end
    if (blk_rst) begin
      val_d = VAL_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= VAL_RESET;
    end else begin
      val_q <= val_d;
    end
  end

  assign aout = val_q;

endmodule : afb_scaler
`default_nettype wire

// >>> design/afb_top.sv
// analog function blocks: scaler, drift monitor, window trigger, preset selector
// assumes block resets, enables and selects come from logic on the same scan clock
`timescale 1ns/10ps
`default_nettype none
module afb_top (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst,
  // shared analog input (x100)
  input  wire logic signed [afb_pkg::AIN_W-1:0]     ain,
  // gain-offset scaler
  input  wire logic                                scl_rst,
  input  wire afb_pkg::afb_scale_t                  scl_scale,
  output logic signed [afb_pkg::VAL_W-1:0]          scl_out,
  // drift monitor
  input  wire logic                                drf_rst,
  input  wire logic                                drf_en,
  input  wire afb_pkg::afb_scale_t                  drf_scale,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     drf_diff_above,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     drf_diff_below,
  output logic                                     drf_out,
  // window trigger
  input  wire logic                                win_rst,
  input  wire afb_pkg::afb_scale_t                  win_scale,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     win_level,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     win_diff,
  output logic                                     win_out,
  // preset selector
  input  wire logic                                sel_rst,
  input  wire logic                                sel_en,
  input  wire logic                                select_high,
  input  wire logic                                select_low,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     first_preset,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     second_preset,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     third_preset,
  input  wire logic signed [afb_pkg::VAL_W-1:0]     fourth_preset,
  output logic signed [afb_pkg::VAL_W-1:0]          sel_out,
  // data word registers
  output afb_pkg::afb_dw_t                          data_word_register
);
  import afb_pkg::*;

  logic signed [VAL_W-1:0] drf_val;
  logic signed [VAL_W-1:0] win_val;

  // -----------------------------------------------------------------
  // scalers
  // -----------------------------------------------------------------
  afb_scaler u_scl (
    .clk     (clk),
    .rst     (rst),
    .blk_rst (scl_rst),
    .ain     (ain),
    .scale   (scl_scale),
    .aout    (scl_out)
  );

  afb_scaler u_drf_scl (
    .clk     (clk),
    .rst     (rst),
    .blk_rst (drf_rst),
    .ain     (ain),
    .scale   (drf_scale),
    .aout    (drf_val)
  );

  afb_scaler u_win_scl (
    .clk     (clk),
    .rst     (rst),
    .blk_rst (win_rst),
    .ain     (ain),
    .scale   (win_scale),
    .aout    (win_val)
  );

  // -----------------------------------------------------------------
  // drift monitor
  // -----------------------------------------------------------------
  logic                    drf_en_q;
  logic                    drf_act_d;
  logic                    drf_act_q;
  logic signed [VAL_W-1:0] drf_ref_d;
  logic signed [VAL_W-1:0] drf_ref_q;
  logic                    drf_out_d;
  logic                    drf_out_q;
  logic signed [VAL_W+1:0] drf_hi;
  logic signed [VAL_W+1:0] drf_lo;

  always_comb begin
    drf_act_d = drf_act_q;
    drf_ref_d = drf_ref_q;
    drf_hi    = (VAL_W+2)'(drf_ref_q) + (VAL_W+2)'(afb_clamp(drf_diff_above, VAL_RESET, LEVEL_MAX));
    drf_lo    = (VAL_W+2)'(drf_ref_q) - (VAL_W+2)'(afb_clamp(drf_diff_below, VAL_RESET, LEVEL_MAX));
    // band check on the running value against the stored reference
    drf_out_d = drf_act_q && (((VAL_W+2)'(drf_val) > drf_hi) || ((VAL_W+2)'(drf_val) < drf_lo));
    if (drf_en && !drf_en_q) begin
      drf_ref_d = drf_val;
      drf_act_d = 1'b1;
      drf_out_d = 1'b0;
    end
    if (drf_rst) begin
      drf_act_d = 1'b0;
      drf_ref_d = VAL_RESET;
      drf_out_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drf_en_q  <= 1'b0;
      drf_act_q <= 1'b0;
      drf_ref_q <= VAL_RESET;
      drf_out_q <= 1'b0;
    end else begin
      // edge history runs through block reset so a held enable does not retrigger
      drf_en_q  <= drf_en;
      drf_act_q <= drf_act_d;
      drf_ref_q <= drf_ref_d;
      drf_out_q <= drf_out_d;
    end
  end

  assign drf_out = drf_out_q;

  // -----------------------------------------------------------------
  // window trigger
  // -----------------------------------------------------------------
  logic                    win_out_d;
  logic                    win_out_q;
  logic signed [VAL_W-1:0] win_on;
  logic signed [VAL_W-1:0] win_df;
  logic signed [VAL_W+1:0] win_top;

  always_comb begin
    win_on    = afb_clamp(win_level, -LEVEL_MAX, LEVEL_MAX);
    win_df    = afb_clamp(win_diff, -LEVEL_MAX, LEVEL_MAX);
    win_top   = (VAL_W+2)'(win_on) + (VAL_W+2)'(win_df);
    win_out_d = win_out_q;
    if (!win_df[VAL_W-1]) begin
      // zero difference gives an empty window, output stays low
      win_out_d = (win_val >= win_on) && ((VAL_W+2)'(win_val) < win_top);
    end else if (win_val > win_on) begin
      win_out_d = 1'b1;
    end else if ((VAL_W+2)'(win_val) <= win_top) begin
      win_out_d = 1'b0;
    end
    if (win_rst) begin
      win_out_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_out_q <= 1'b0;
    end else begin
      win_out_q <= win_out_d;
    end
  end

  assign win_out = win_out_q;

  // -----------------------------------------------------------------
  // preset selector
  // -----------------------------------------------------------------
  logic signed [VAL_W-1:0] preset_raw [NPRESET];
  logic signed [VAL_W-1:0] preset_c   [NPRESET];
  logic                    sel_en_q;
  logic signed [VAL_W-1:0] sel_d;
  logic signed [VAL_W-1:0] sel_q;
  afb_sel_t                sel_code;

  assign preset_raw[0] = first_preset;
  assign preset_raw[1] = second_preset;
  assign preset_raw[2] = third_preset;
  assign preset_raw[3] = fourth_preset;

  for (genvar i = 0; i < NPRESET; i++) begin : g_preset
    assign preset_c[i] = afb_clamp(preset_raw[i], -LEVEL_MAX, LEVEL_MAX);
  end

  always_comb begin
    sel_code = afb_sel_t'({select_high, select_low});
    sel_d    = sel_q;
    if (sel_en && !sel_en_q) begin
      unique case (sel_code)
        SEL_FIRST:  sel_d = preset_c[0];
        SEL_SECOND: sel_d = preset_c[1];
        SEL_THIRD:  sel_d = preset_c[2];
        SEL_FOURTH: sel_d = preset_c[3];
      endcase
    end
    if (sel_rst) begin
      sel_d = VAL_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_en_q <= 1'b0;
      sel_q    <= VAL_RESET;
    end else begin
      sel_en_q <= sel_en;
      sel_q    <= sel_d;
    end
  end

  assign sel_out = sel_q;

  // -----------------------------------------------------------------
  // data words
  // -----------------------------------------------------------------
  // copies of the flops, so the words change in the same cycle as the blocks
  assign data_word_register.scaler = scl_out;
  assign data_word_register.drift  = drf_val;
  assign data_word_register.window = win_val;
  assign data_word_register.preset = sel_q;

endmodule : afb_top
`default_nettype wire

// >>> test/afb_peer.sv
// enable pulse source standing in for an upstream function block
// assumes the bench raises start for one falling edge
`timescale 1ns/10ps
`default_nettype none
module afb_peer (
  // clock
  input  wire logic clk,
  // request and enable
  input  wire logic start,
  output logic      en
);
  logic [1:0] cnt_q = 2'h0;
  // upstream logic changes off the scan edge, like the bench
  always @(negedge clk) begin
    if (start) begin
      cnt_q <= 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  assign en = (cnt_q != 2'h0);
endmodule : afb_peer
`default_nettype wire

// >>> test/afb_top_sva.sv
// checker for the analog function blocks, bound to afb_top
// assumes parameters stay inside their documented ranges
`timescale 1ns/10ps
`default_nettype none
module afb_top_sva (
  input wire logic                             clk,
  input wire logic                             rst,
  input wire logic signed [afb_pkg::AIN_W-1:0] ain,
  input wire logic                             scl_rst,
  input wire afb_pkg::afb_scale_t              scl_scale,
  input wire logic signed [afb_pkg::VAL_W-1:0] scl_out,
  input wire logic                             drf_rst,
  input wire logic                             drf_en,
  input wire logic                             drf_out,
  input wire logic                             win_rst,
  input wire logic signed [afb_pkg::VAL_W-1:0] win_level,
  input wire logic signed [afb_pkg::VAL_W-1:0] win_diff,
  input wire logic                             win_out,
  input wire logic                             sel_rst,
  input wire logic                             sel_en,
  input wire logic                             select_high,
  input wire logic                             select_low,
  input wire logic signed [afb_pkg::VAL_W-1:0] first_preset,
  input wire logic signed [afb_pkg::VAL_W-1:0] second_preset,
  input wire logic signed [afb_pkg::VAL_W-1:0] third_preset,
  input wire logic signed [afb_pkg::VAL_W-1:0] fourth_preset,
  input wire logic signed [afb_pkg::VAL_W-1:0] sel_out,
  input wire afb_pkg::afb_dw_t                 data_word_register
);
  import afb_pkg::*;
  logic sel_q;
  logic drf_q;
  logic ok;
  logic w_in;
  logic w_hi;
  logic w_lo;
  logic signed [VAL_W-1:0] scl_x;
  logic signed [VAL_W-1:0] pick;
  logic signed [VAL_W-1:0] wv;
  // edge history cleared by reset, as the blocks do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
      drf_q <= 1'b0;
    end else begin
      sel_q <= sel_en;
      drf_q <= drf_en;
    end
  end
  always_comb begin
    ok = scl_scale.gain <= GAIN_MAX && scl_scale.gain >= -GAIN_MAX
      && scl_scale.offset <= OFS_MAX && scl_scale.offset >= -OFS_MAX;
    scl_x = VAL_W'(ain) * VAL_W'(scl_scale.gain) + VAL_W'(scl_scale.offset) * FIX_SCALE;
    pick = select_high ? (select_low ? fourth_preset : third_preset)
                       : (select_low ? second_preset : first_preset);
    // presets beyond the range are expected clamped to it
    pick = (pick > LEVEL_MAX) ? LEVEL_MAX : ((pick < -LEVEL_MAX) ? -LEVEL_MAX : pick);
    wv = data_word_register.window;
    w_in = wv >= win_level && wv < win_level + win_diff;
    w_hi = wv > win_level;
    w_lo = wv <= win_level + win_diff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sel_edge;
    sel_en && !sel_q && !sel_rst;
  endsequence
  sequence s_drf_edge;
    drf_en && !drf_q && !drf_rst;
  endsequence
  property p_scl_val;  !scl_rst && ok |=> scl_out == $past(scl_x); endproperty
  property p_scl_rst;  scl_rst |=> scl_out == VAL_RESET; endproperty
  property p_dw;       data_word_register.scaler == scl_out && data_word_register.preset == sel_out; endproperty
  property p_sel_hold; !(sel_en && !sel_q) && !sel_rst |=> $stable(sel_out); endproperty
  property p_sel_pick; s_sel_edge |=> sel_out == $past(pick); endproperty
  property p_sel_rst;  sel_rst |=> sel_out == VAL_RESET; endproperty
  property p_drf_edge; s_drf_edge |=> !drf_out; endproperty
  property p_drf_rst;  drf_rst |=> !drf_out [*2]; endproperty
  property p_win_pos;  !win_rst && win_diff >= 0 |=> win_out == $past(w_in); endproperty
  property p_win_neg;  !win_rst && win_diff < 0 && (w_hi || w_lo) |=> win_out == $past(w_hi); endproperty
  a_scl_val:  assert property (p_scl_val)  else $error("scaler result wrong");
  a_scl_rst:  assert property (p_scl_rst)  else $error("scaler not cleared");
  a_dw:       assert property (p_dw)       else $error("data word differs");
  a_sel_hold: assert property (p_sel_hold) else $error("selector moved without edge");
  a_sel_pick: assert property (p_sel_pick) else $error("selector picked wrong");
  a_sel_rst:  assert property (p_sel_rst)  else $error("selector not cleared");
  a_drf_edge: assert property (p_drf_edge) else $error("drift high at capture");
  a_drf_rst:  assert property (p_drf_rst)  else $error("drift high after reset");
  a_win_pos:  assert property (p_win_pos)  else $error("window level wrong");
  a_win_neg:  assert property (p_win_neg)  else $error("hysteresis wrong");
endmodule : afb_top_sva
bind afb_top afb_top_sva chk_u (.*);
`default_nettype wire

// >>> test/afb_top_test.sv
// self-checking bench for the analog function blocks
// assumes afb_top, afb_peer and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module afb_top_test;
  import afb_pkg::*;
  typedef struct packed {
    logic signed [31:0] a;
    logic signed [15:0] g;
    logic signed [15:0] o;
    logic signed [47:0] x;
  } afb_row_t;
  // last row has gain and offset beyond range: clamped
  localparam afb_row_t ROWS [5] = '{'{32'sd100, 16'sd3, 16'sd2, 48'sd500},
    '{-32'sd250, -16'sd10000, 16'sd20000, 48'sd4500000},
    '{32'sd2000000, 16'sd10000, -16'sd20000, 48'sd19998000000},
    '{32'sd7, 16'sd0, -16'sd1, -48'sd100},
    '{32'sd1, 16'sd12000, -16'sd25000, -48'sd1990000}};
  int da[4] = '{5250, 5251, 4850, 4849};
  int wa[9] = '{999, 1000, 1499, 1500, 1001, 700, 500, 700, 1001};
  bit de[4] = '{0, 1, 0, 1};
  bit we[9] = '{0, 1, 1, 0, 1, 1, 0, 0, 1};
  logic clk = 1'b0, rst = 1'b1, scl_rst = 1'b0, drf_rst = 1'b0, win_rst = 1'b0;
  logic sel_rst = 1'b0, drf_go = 1'b0, sel_go = 1'b0, sh = 1'b0, sl = 1'b0;
  logic drf_en, sel_en, drf_out, win_out;
  logic signed [AIN_W-1:0] ain = '0;
  afb_scale_t scl_sc = '0, drf_sc = '{16'sd2, 16'sd0}, win_sc = '{16'sd1, 16'sd0};
  logic signed [VAL_W-1:0] wd = 48'sd500, scl_out, sel_out;
  logic signed [VAL_W-1:0] pv [4] = '{48'sd2000000, -48'sd2000000, 48'sd12345, -48'sd1};
  afb_dw_t dw;
  int bad_count = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  afb_top dut_u (.clk(clk), .rst(rst), .ain(ain), .scl_rst(scl_rst), .scl_scale(scl_sc),
    .scl_out(scl_out), .drf_rst(drf_rst), .drf_en(drf_en), .drf_scale(drf_sc),
    .drf_diff_above(48'sd500), .drf_diff_below(48'sd300), .drf_out(drf_out), .win_rst(win_rst),
    .win_scale(win_sc), .win_level(48'sd1000), .win_diff(wd), .win_out(win_out),
    .sel_rst(sel_rst), .sel_en(sel_en), .select_high(sh), .select_low(sl),
    .first_preset(pv[0]), .second_preset(pv[1]), .third_preset(pv[2]),
    .fourth_preset(pv[3]), .sel_out(sel_out), .data_word_register(dw));
  afb_peer drf_pu (.clk(clk), .start(drf_go), .en(drf_en));
  afb_peer sel_pu (.clk(clk), .start(sel_go), .en(sel_en));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // request seen by the peer one falling edge later, output settled after the next
  task automatic pulse(input bit to_sel);
    if (to_sel) begin
      sel_go <= 1'b1;
    end else begin
      drf_go <= 1'b1;
    end
    tick(1);
    sel_go <= 1'b0;
    drf_go <= 1'b0;
    tick(1);
  endtask : pulse
  task automatic check(input logic [VAL_W-1:0] seen, input logic [VAL_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: got %0d, expected %0d", $time, $signed(seen), $signed(exp));
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
  initial begin
    tick(12);
    check(scl_out, 0);
    check(sel_out, 0);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      ain = ROWS[i].a;
      scl_sc = '{ROWS[i].g, ROWS[i].o};
      tick(1);
      check(scl_out, ROWS[i].x);
      check(dw.scaler, ROWS[i].x);
    end
    check(drf_out, 0);
    scl_rst = 1'b1;
    tick(1);
    check(scl_out, 0);
    scl_rst = 1'b0;
    $display("scaler done");
    for (int s = 0; s < 4; s++) begin
      {sh, sl} = s[1:0];
      pulse(1'b1);
      check(sel_out, pv[s]);
      check(dw.preset, pv[s]);
      {sh, sl} = ~s[1:0];
      tick(4);
      check(sel_out, pv[s]);
    end
    pv[2] = 48'sd2500000;
    {sh, sl} = 2'b10;
    pulse(1'b1);
    check(sel_out, 48'sd2000000);
    sel_rst = 1'b1;
    tick(1);
    check(sel_out, 0);
    sel_rst = 1'b0;
    $display("selector done");
    ain = 5000;
    tick(2);
    pulse(1'b0);
    check(drf_out, 0);
    foreach (da[i]) begin
      ain = da[i];
      tick(2);
      check(drf_out, de[i]);
    end
    check(dw.drift, 48'sd9698);
    drf_rst = 1'b1;
    tick(1);
    drf_rst = 1'b0;
    tick(3);
    check(drf_out, 0);
    $display("drift done");
    foreach (wa[i]) begin
      if (i == 4) begin
        wd = -48'sd500;
      end
      ain = wa[i];
      tick(2);
      check(win_out, we[i]);
    end
    check(dw.window, 48'sd1001);
    win_rst = 1'b1;
    tick(1);
    check(win_out, 0);
    $display("window done");
    give_verdict();
  end
endmodule : afb_top_test
`default_nettype wire
